// file: shared/acr_consts.svh
// Register offsets, field positions, reset values and datapath constants
// Functional notes
// - Positive reference select in bits 3:2 routes 01 to the high supply, 10 to pin 0, 11 to input 0.
// - Negative reference select in bits 1:0 routes 01 to the low supply, 10 to pin 0, 11 to input 1.
// - The reference select register at 06h resets to 05h and its upper four bits reset to zero.
// - A signed 24-bit offset word lives in byte registers 07h to 09h, all reset to zero.
// - Each conversion first has the offset word subtracted from the raw result.
// - An unsigned 24-bit scale word lives in byte registers 0Ah to 0Ch and resets to 400000h.
// - The difference is multiplied by the scale word over 400000h, unity gain at reset.
// - Locations 0Eh and 0Fh are read only, read zero and ignore writes.
// - Location 0Dh is read only; it resets to FFh and is taken here to read FFh.
// - The amplifier register at 10h resets to 00h with bypass at bit 7 and gain in bits 2:0.
// - Gain code 000 gives 1, 110 gives 64, 111 gives 128; 001 to 101 are reserved.
// - Bypass clear uses the amplifier path, bypass set skips it.
`ifndef ACR_CONSTS_SVH
`define ACR_CONSTS_SVH

`define ACR_OFS_REF        5'h06
`define ACR_OFS_OFC_LO     5'h07
`define ACR_OFS_OFC_MID    5'h08
`define ACR_OFS_OFC_HI     5'h09
`define ACR_OFS_FSC_LO     5'h0A
`define ACR_OFS_FSC_MID    5'h0B
`define ACR_OFS_FSC_HI     5'h0C
`define ACR_OFS_RSV_ONES   5'h0D
`define ACR_OFS_RSV_ZA     5'h0E
`define ACR_OFS_RSV_ZB     5'h0F
`define ACR_OFS_AMP        5'h10

`define ACR_RST_REF        8'h05
`define ACR_RST_OFC        24'h000000
`define ACR_RST_FSC        24'h400000
`define ACR_RST_RSV_ONES   8'hFF
`define ACR_RST_AMP        8'h00

`define ACR_REF_POS_MSB    3
`define ACR_REF_POS_LSB    2
`define ACR_REF_NEG_MSB    1
`define ACR_REF_NEG_LSB    0
`define ACR_REF_USED_MASK  8'h0F
`define ACR_AMP_BYPASS_BIT 7
`define ACR_AMP_GAIN_MSB   2
`define ACR_AMP_GAIN_LSB   0
`define ACR_AMP_USED_MASK  8'h87

`define ACR_SCALE_SHIFT    22
`define ACR_SAT_MAX        24'h7FFFFF
`define ACR_SAT_MIN        24'h800000

`endif

// file: shared/acr_pkg.sv
// Types shared by the calibration register block
package acr_pkg;

	typedef enum logic [1:0]
	{
		ACR_REFP_RSVD  = 2'b00,
		ACR_REFP_AVH   = 2'b01,
		ACR_REFP_PIN0  = 2'b10,
		ACR_REFP_ANALOG_INPUT0  = 2'b11
	} acr_ref_pos_t;

	typedef enum logic [1:0]
	{
		ACR_REFN_RSVD  = 2'b00,
		ACR_REFN_AVL   = 2'b01,
		ACR_REFN_PIN0  = 2'b10,
		ACR_REFN_ANALOG_INPUT1  = 2'b11
	} acr_ref_neg_t;

	typedef enum logic [1:0]
	{
		ACR_CAL_IDLE   = 2'b00,
		ACR_CAL_SCALE  = 2'b01,
		ACR_CAL_DONE   = 2'b10
	} acr_cal_state_t;

endpackage

// file: core/acr_ref_route.sv
// Reference and amplifier decode into one-hot routing selects
`include "acr_consts.svh"
module acr_ref_route
	import acr_pkg::*;
(
	input  wire logic [7:0] ref_reg,
	input  wire logic [7:0] amp_reg,
	output logic      [3:0] ref_pos_onehot,
	output logic      [3:0] ref_neg_onehot,
	output logic      [7:0] gain_value,
	output logic            gain_reserved,
	output logic            amp_bypass
);

	acr_ref_pos_t ref_pos_select;
	acr_ref_neg_t ref_neg_select;

	assign ref_pos_select = acr_ref_pos_t'(ref_reg[`ACR_REF_POS_MSB:`ACR_REF_POS_LSB]);
	assign ref_neg_select = acr_ref_neg_t'(ref_reg[`ACR_REF_NEG_MSB:`ACR_REF_NEG_LSB]);

	always_comb
	begin
		ref_pos_onehot = 4'h0;
		case (ref_pos_select)
			ACR_REFP_AVH:  ref_pos_onehot = 4'h1;
			ACR_REFP_PIN0: ref_pos_onehot = 4'h2;
			ACR_REFP_ANALOG_INPUT0: ref_pos_onehot = 4'h4;
			default:       ref_pos_onehot = 4'h8;
		endcase
	end

	always_comb
	begin
		ref_neg_onehot = 4'h0;
		case (ref_neg_select)
			ACR_REFN_AVL:  ref_neg_onehot = 4'h1;
			ACR_REFN_PIN0: ref_neg_onehot = 4'h2;
			ACR_REFN_ANALOG_INPUT1: ref_neg_onehot = 4'h4;
			default:       ref_neg_onehot = 4'h8;
		endcase
	end

	always_comb
	begin
		gain_reserved = 1'b0;
		case (amp_reg[`ACR_AMP_GAIN_MSB:`ACR_AMP_GAIN_LSB])
			3'h0:    gain_value = 8'h01;
			3'h6:    gain_value = 8'h40;
			3'h7:    gain_value = 8'h80;
			default:
			begin
				// Reserved codes fall back to unity so the path stays sane
				gain_value    = 8'h01;
				gain_reserved = 1'b1;
			end
		endcase
	end

	assign amp_bypass = amp_reg[`ACR_AMP_BYPASS_BIT];

endmodule

// file: core/acr_cal_path.sv
// Two-stage offset and full-scale correction of a conversion result
`include "acr_consts.svh"
module acr_cal_path
	import acr_pkg::*;
(
	input  wire logic               clk,
	input  wire logic               rst,
	input  wire logic               in_valid,
	input  wire logic signed [23:0] in_data,
	input  wire logic signed [23:0] offset_word,
	input  wire logic        [23:0] scale_word,
	output logic                    busy,
	output logic                    out_valid,
	output logic signed      [23:0] out_data
);

	acr_cal_state_t    state_q;
	logic signed [24:0] diff_q;
	logic        [23:0] scale_q;
	logic signed [49:0] prod;
	logic signed [49:0] scaled;

	function automatic logic [23:0] sat24(input logic signed [49:0] v);
		if (v > 50'sh7FFFFF)
			sat24 = `ACR_SAT_MAX;
		else if (v < -50'sh800000)
			sat24 = `ACR_SAT_MIN;
		else
			sat24 = v[23:0];
	endfunction

	assign prod   = diff_q * $signed({1'b0, scale_q});
	assign scaled = prod >>> `ACR_SCALE_SHIFT;
	assign busy   = (state_q == ACR_CAL_SCALE);

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			state_q <= ACR_CAL_IDLE;
		else
		begin
			case (state_q)
				ACR_CAL_IDLE:  state_q <= in_valid ? ACR_CAL_SCALE : ACR_CAL_IDLE;
				ACR_CAL_SCALE: state_q <= ACR_CAL_DONE;
				ACR_CAL_DONE:  state_q <= in_valid ? ACR_CAL_SCALE : ACR_CAL_IDLE;
				default:       state_q <= ACR_CAL_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			diff_q  <= 25'h0;
			scale_q <= 24'h000000;
		end
		else if (in_valid && !busy)
		begin
			// Scale word is captured with the sample so a mid-sample write is harmless
			diff_q  <= {in_data[23], in_data} - {offset_word[23], offset_word};
			scale_q <= scale_word;
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			out_valid <= 1'b0;
			out_data  <= 24'h000000;
		end
		else
		begin
			out_valid <= busy;
			if (busy)
				out_data <= sat24(scaled);
		end
	end

endmodule

// file: core/acr_regs.sv
// Calibration and configuration register bank with correction datapath
//
// Our own choice: strobed register access.
`include "acr_consts.svh"
module acr_regs
	import acr_pkg::*;
(
	input  wire logic        CLOCK,
	input  wire logic        SYS_RST,
	input  wire logic [4:0]  REG_ADDR,
	input  wire logic [7:0]  REG_WDATA,
	input  wire logic        REG_WR,
	input  wire logic        REG_RD,
	output logic      [7:0]  REG_RDATA,
	input  wire logic        RAW_VALID,
	input  wire logic [23:0] RAW_DATA,
	output logic             RAW_READY,
	output logic             CAL_VALID,
	output logic      [23:0] CAL_DATA,
	output logic      [3:0]  REF_POS_ROUTE,
	output logic      [3:0]  REF_NEG_ROUTE,
	output logic      [7:0]  AMP_GAIN,
	output logic             AMP_GAIN_RSVD,
	output logic             AMP_BYPASS
);

	logic [7:0]  ref_q;
	logic [7:0]  amp_q;
	logic [23:0] ofc_q;
	logic [23:0] fsc_q;
	logic [7:0]  rdata_d;
	logic        busy;
	logic        cal_valid;
	logic [23:0] cal_data;
	logic [3:0]  pos_route;
	logic [3:0]  neg_route;
	logic [7:0]  gain_val;
	logic        gain_rsvd;
	logic        bypass;

	function automatic logic [23:0] put_byte(input logic [23:0] w, input logic [1:0] idx,
		input logic [7:0] b);
		logic [23:0] r;
		r = w;
		case (idx)
			2'h0:    r[7:0]   = b;
			2'h1:    r[15:8]  = b;
			default: r[23:16] = b;
		endcase
		put_byte = r;
	endfunction

	always_ff @(posedge CLOCK or posedge SYS_RST)
	begin
		if (SYS_RST)
			ref_q <= `ACR_RST_REF;
		else if (REG_WR && REG_ADDR == `ACR_OFS_REF)
			// Reserved upper bits are kept at zero whatever is written
			ref_q <= REG_WDATA & `ACR_REF_USED_MASK;
	end

	always_ff @(posedge CLOCK or posedge SYS_RST)
	begin
		if (SYS_RST)
			amp_q <= `ACR_RST_AMP;
		else if (REG_WR && REG_ADDR == `ACR_OFS_AMP)
			amp_q <= REG_WDATA & `ACR_AMP_USED_MASK;
	end

	always_ff @(posedge CLOCK or posedge SYS_RST)
	begin
		if (SYS_RST)
			ofc_q <= `ACR_RST_OFC;
		else if (REG_WR)
		begin
			if (REG_ADDR == `ACR_OFS_OFC_LO)
				ofc_q <= put_byte(ofc_q, 2'h0, REG_WDATA);
			else if (REG_ADDR == `ACR_OFS_OFC_MID)
				ofc_q <= put_byte(ofc_q, 2'h1, REG_WDATA);
			else if (REG_ADDR == `ACR_OFS_OFC_HI)
				ofc_q <= put_byte(ofc_q, 2'h2, REG_WDATA);
		end
	end

	always_ff @(posedge CLOCK or posedge SYS_RST)
	begin
		if (SYS_RST)
			fsc_q <= `ACR_RST_FSC;
		else if (REG_WR)
		begin
			if (REG_ADDR == `ACR_OFS_FSC_LO)
				fsc_q <= put_byte(fsc_q, 2'h0, REG_WDATA);
			else if (REG_ADDR == `ACR_OFS_FSC_MID)
				fsc_q <= put_byte(fsc_q, 2'h1, REG_WDATA);
			else if (REG_ADDR == `ACR_OFS_FSC_HI)
				fsc_q <= put_byte(fsc_q, 2'h2, REG_WDATA);
		end
	end

	// Read mux; reserved and unmapped addresses drop writes by having no storage
	always_comb
	begin
		if (REG_ADDR == `ACR_OFS_REF)
			rdata_d = ref_q;
		else if (REG_ADDR == `ACR_OFS_OFC_LO)
			rdata_d = ofc_q[7:0];
		else if (REG_ADDR == `ACR_OFS_OFC_MID)
			rdata_d = ofc_q[15:8];
		else if (REG_ADDR == `ACR_OFS_OFC_HI)
			rdata_d = ofc_q[23:16];
		else if (REG_ADDR == `ACR_OFS_FSC_LO)
			rdata_d = fsc_q[7:0];
		else if (REG_ADDR == `ACR_OFS_FSC_MID)
			rdata_d = fsc_q[15:8];
		else if (REG_ADDR == `ACR_OFS_FSC_HI)
			rdata_d = fsc_q[23:16];
		else if (REG_ADDR == `ACR_OFS_RSV_ONES)
			rdata_d = `ACR_RST_RSV_ONES;
		else if (REG_ADDR == `ACR_OFS_RSV_ZA || REG_ADDR == `ACR_OFS_RSV_ZB)
			rdata_d = 8'h00;
		else if (REG_ADDR == `ACR_OFS_AMP)
			rdata_d = amp_q;
		else
			rdata_d = 8'h00;
	end

	always_ff @(posedge CLOCK or posedge SYS_RST)
	begin
		if (SYS_RST)
			REG_RDATA <= 8'h00;
		else if (REG_RD)
			REG_RDATA <= rdata_d;
		else
			REG_RDATA <= 8'h00;
	end

	acr_ref_route u_route
	(
		.ref_reg        (ref_q),
		.amp_reg        (amp_q),
		.ref_pos_onehot (pos_route),
		.ref_neg_onehot (neg_route),
		.gain_value     (gain_val),
		.gain_reserved  (gain_rsvd),
		.amp_bypass     (bypass)
	);

	acr_cal_path u_cal
	(
		.clk         (CLOCK),
		.rst         (SYS_RST),
		.in_valid    (RAW_VALID),
		.in_data     (RAW_DATA),
		.offset_word (ofc_q),
		.scale_word  (fsc_q),
		.busy        (busy),
		.out_valid   (cal_valid),
		.out_data    (cal_data)
	);

	assign RAW_READY = !busy;
	assign CAL_VALID = cal_valid;
	assign CAL_DATA  = cal_data;

	// Routing outputs registered so the analog switches see clean levels
	always_ff @(posedge CLOCK or posedge SYS_RST)
	begin
		if (SYS_RST)
		begin
			REF_POS_ROUTE <= 4'h1;
			REF_NEG_ROUTE <= 4'h1;
			AMP_GAIN      <= 8'h01;
			AMP_GAIN_RSVD <= 1'b0;
			AMP_BYPASS    <= 1'b0;
		end
		else
		begin
			REF_POS_ROUTE <= pos_route;
			REF_NEG_ROUTE <= neg_route;
			AMP_GAIN      <= gain_val;
			AMP_GAIN_RSVD <= gain_rsvd;
			AMP_BYPASS    <= bypass;
		end
	end

endmodule

// file: test/acr_regs_props.sv
// Port checker for the calibration register bank
module acr_regs_props
	import acr_pkg::*;
(
	input wire logic        CLOCK,
	input wire logic        SYS_RST,
	input wire logic [4:0]  REG_ADDR,
	input wire logic [7:0]  REG_WDATA,
	input wire logic        REG_WR,
	input wire logic        REG_RD,
	input wire logic [7:0]  REG_RDATA,
	input wire logic        RAW_VALID,
	input wire logic        RAW_READY,
	input wire logic        CAL_VALID,
	input wire logic [3:0]  REF_POS_ROUTE,
	input wire logic [3:0]  REF_NEG_ROUTE,
	input wire logic [7:0]  AMP_GAIN,
	input wire logic        AMP_GAIN_RSVD,
	input wire logic        AMP_BYPASS
);
	default clocking cb @(posedge CLOCK);
	endclocking
	default disable iff (SYS_RST);
	function automatic logic [7:0] gain_of(input logic [2:0] g);
		return (g == 3'h7) ? 8'h80 : ((g == 3'h6) ? 8'h40 : 8'h01);
	endfunction
	property p_rd_ones;
		REG_RD && REG_ADDR == 5'h0D |=> REG_RDATA == 8'hFF;
	endproperty
	a_rd_ones: assert property (p_rd_ones) else $error("bad ones read");
	property p_rd_zero;
		REG_RD && (REG_ADDR == 5'h0E || REG_ADDR == 5'h0F) |=> REG_RDATA == 8'h00;
	endproperty
	a_rd_zero: assert property (p_rd_zero) else $error("bad zero read");
	property p_ref_rsvd;
		REG_RD && REG_ADDR == 5'h06 |=> REG_RDATA[7:4] == 4'h0;
	endproperty
	a_ref_rsvd: assert property (p_ref_rsvd) else $error("reference upper bits set");
	property p_amp_rsvd;
		REG_RD && REG_ADDR == 5'h10 |=> REG_RDATA[6:3] == 4'h0;
	endproperty
	a_amp_rsvd: assert property (p_amp_rsvd) else $error("amplifier bits set");
	// Positive route decode; code plus three wraps to the one-hot position
	property p_ref_pos;
		REG_WR && REG_ADDR == 5'h06 |->
			##2 REF_POS_ROUTE == 4'h1 << 2'($past(REG_WDATA[3:2], 2) + 2'h3);
	endproperty
	a_ref_pos: assert property (p_ref_pos) else $error("positive route wrong");
	property p_ref_neg;
		REG_WR && REG_ADDR == 5'h06 |->
			##2 REF_NEG_ROUTE == 4'h1 << 2'($past(REG_WDATA[1:0], 2) + 2'h3);
	endproperty
	a_ref_neg: assert property (p_ref_neg) else $error("negative route wrong");
	property p_gain;
		REG_WR && REG_ADDR == 5'h10 |-> ##2 AMP_GAIN == gain_of($past(REG_WDATA[2:0], 2))
			&& AMP_GAIN_RSVD == ($past(REG_WDATA[2:0], 2) inside {[3'h1 : 3'h5]});
	endproperty
	a_gain: assert property (p_gain) else $error("gain wrong");
	property p_bypass;
		REG_WR && REG_ADDR == 5'h10 |-> ##2 AMP_BYPASS == $past(REG_WDATA[7], 2);
	endproperty
	a_bypass: assert property (p_bypass) else $error("bypass wrong");
	property p_conv;
		RAW_VALID && RAW_READY |=> !RAW_READY ##1 CAL_VALID;
	endproperty
	a_conv: assert property (p_conv) else $error("result timing wrong");
	property p_pulse;
		CAL_VALID |=> !CAL_VALID;
	endproperty
	a_pulse: assert property (p_pulse) else $error("result pulse too long");
endmodule
bind acr_regs acr_regs_props u_props (.CLOCK(CLOCK), .SYS_RST(SYS_RST), .REG_ADDR(REG_ADDR),
	.REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
	.RAW_VALID(RAW_VALID), .RAW_READY(RAW_READY), .CAL_VALID(CAL_VALID),
	.REF_POS_ROUTE(REF_POS_ROUTE), .REF_NEG_ROUTE(REF_NEG_ROUTE), .AMP_GAIN(AMP_GAIN),
	.AMP_GAIN_RSVD(AMP_GAIN_RSVD), .AMP_BYPASS(AMP_BYPASS));

// file: test/acr_regs_tb.sv
// Self-checking bench for the calibration register bank
module acr_regs_tb
	import acr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] rst_tab [11] = '{8'h05, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h40, 8'hFF, 8'h00, 8'h00, 8'h00};
	localparam logic [7:0] gain_tab [8] = '{8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h01,
		8'h40, 8'h80};
	localparam logic [3:0] ref_tab [4] = '{4'h8, 4'h1, 4'h2, 4'h4};
	localparam logic [7:0] cal_tab [6] = '{8'h34, 8'h12, 8'h00, 8'h02, 8'h00, 8'h60};
	logic        clock = 1'b0;
	logic        sys_rst = 1'b1;
	logic [4:0]  reg_addr = 5'h00;
	logic [7:0]  reg_wdata = 8'h00;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic        raw_valid = 1'b0;
	logic [23:0] raw_data = 24'h000000;
	logic [23:0] ofc_w = 24'h000000;
	logic [23:0] fsc_w = 24'h400000;
	logic [7:0]  reg_rdata, amp_gain;
	logic [3:0]  pos_route, neg_route;
	logic [23:0] cal_data;
	logic        raw_ready, cal_valid, gain_rsvd, bypass;
	int          n_errors = 0;
	int          checked = 0;
	int          cycles = 0;
	always #2.5 clock = ~clock;
	acr_regs dut (.CLOCK(clock), .SYS_RST(sys_rst), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
		.REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .RAW_VALID(raw_valid),
		.RAW_DATA(raw_data), .RAW_READY(raw_ready), .CAL_VALID(cal_valid),
		.CAL_DATA(cal_data), .REF_POS_ROUTE(pos_route), .REF_NEG_ROUTE(neg_route),
		.AMP_GAIN(amp_gain), .AMP_GAIN_RSVD(gain_rsvd), .AMP_BYPASS(bypass));
	task automatic tally_and_finish();
		$display("errors %0d checks %0d", n_errors, checked);
		if (n_errors == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp)
		begin
			n_errors++;
			$display("[ERR] %0t byte %h want %h", $time, got, exp);
		end
	endtask
	task automatic chk24(input logic [23:0] got, input logic [23:0] exp);
		checked++;
		if (got !== exp)
		begin
			n_errors++;
			$display("[ERR] %0t result %h want %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		@(posedge clock);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [4:0] a, input logic [7:0] exp);
		@(posedge clock);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1;
		chk8(reg_rdata, exp);
	endtask
	task automatic settle();
		repeat (2) @(posedge clock);
		#1;
	endtask
	// Floor shift keeps negative results rounding the same way as the datapath
	function automatic logic [23:0] cal_exp(input logic [23:0] r);
		longint p;
		p = ((longint'($signed(r)) - longint'($signed(ofc_w))) * longint'(fsc_w)) >>> 22;
		if (p > 64'sh7FFFFF)
			return 24'h7FFFFF;
		if (p < -64'sh800000)
			return 24'h800000;
		return p[23:0];
	endfunction
	task automatic conv(input logic [23:0] r);
		int n;
		n = 0;
		@(posedge clock);
		raw_valid <= 1'b1;
		raw_data <= r;
		@(posedge clock);
		raw_valid <= 1'b0;
		#1;
		while (cal_valid !== 1'b1 && n < 4)
		begin
			@(posedge clock);
			#1;
			n++;
		end
		chk8({7'h00, cal_valid}, 8'h01);
		chk24(cal_data, cal_exp(r));
	endtask
	task automatic t_reset();
		for (int i = 0; i < 11; i++)
			rd(5'(6 + i), rst_tab[i]);
		rd(5'h1F, 8'h00);
		chk8({pos_route, neg_route}, 8'h11);
		chk8(amp_gain, 8'h01);
	endtask
	task automatic t_ref();
		for (int c = 0; c < 4; c++)
		begin
			wr(5'h06, {4'h0, 2'(c), 2'(3 - c)});
			settle();
			chk8({pos_route, neg_route}, {ref_tab[c], ref_tab[3 - c]});
			rd(5'h06, {4'h0, 2'(c), 2'(3 - c)});
		end
	endtask
	task automatic t_amp();
		for (int g = 0; g < 8; g++)
		begin
			wr(5'h10, {1'(g & 1), 4'h0, 3'(g)});
			settle();
			chk8(amp_gain, gain_tab[g]);
			chk8({7'h00, gain_rsvd}, {7'h00, 1'(g > 0 && g < 6)});
			chk8({7'h00, bypass}, {7'h00, 1'(g & 1)});
			rd(5'h10, {1'(g & 1), 4'h0, 3'(g)});
		end
	endtask
	task automatic t_rsvd();
		wr(5'h0D, 8'h00);
		wr(5'h0E, 8'hFF);
		wr(5'h0F, 8'hA5);
		wr(5'h05, 8'h5A);
		rd(5'h0D, 8'hFF);
		rd(5'h0E, 8'h00);
		rd(5'h0F, 8'h00);
		rd(5'h05, 8'h00);
	endtask
	task automatic t_cal();
		conv(24'h01E240);
		for (int i = 0; i < 6; i++)
			wr(5'(7 + i), cal_tab[i]);
		ofc_w = 24'h001234;
		fsc_w = 24'h600002;
		rd(5'h07, 8'h34);
		rd(5'h08, 8'h12);
		rd(5'h0C, 8'h60);
		conv(24'h002000);
		conv(24'hFFF000);
		conv(24'h7FFFF0);
		conv(24'h800000);
		wr(5'h09, 8'hFF);
		ofc_w = 24'hFF1234;
		conv(24'h000100);
	endtask
	always @(posedge clock)
	begin
		cycles <= cycles + 1;
		if (cycles == 5000)
		begin
			n_errors++;
			tally_and_finish();
		end
	end
	initial
	begin
		repeat (8) @(posedge clock);
		sys_rst <= 1'b0;
		t_reset();
		t_ref();
		t_amp();
		t_rsvd();
		t_cal();
		// Second reset must restore every location after reconfiguration
		@(posedge clock);
		sys_rst <= 1'b1;
		repeat (2) @(posedge clock);
		sys_rst <= 1'b0;
		t_reset();
		tally_and_finish();
	end
endmodule
